// file: core/dpc_entry_table.sv
// Purpose: Flip-flop table of defect coordinates
// Assumes: Single entry write or whole-table copy, copy wins
// Notes:   Contents read out as flat vectors, entry 0 lowest
`timescale 1ns/1ps
module dpc_entry_table #(
  parameter int DEPTH   = dpc_pkg::DEPTH,
  parameter int IDX_W   = dpc_pkg::IDX_W,
  parameter int COORD_W = dpc_pkg::COORD_W
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     wr_en_in,
  input  wire logic [IDX_W-1:0]         wr_idx_in,
  input  wire logic [COORD_W-1:0]       wr_x_in,
  input  wire logic [COORD_W-1:0]       wr_y_in,
  input  wire logic                     copy_en_in,
  input  wire logic [DEPTH*COORD_W-1:0] copy_x_in,
  input  wire logic [DEPTH*COORD_W-1:0] copy_y_in,
  output logic      [DEPTH*COORD_W-1:0] x_out,
  output logic      [DEPTH*COORD_W-1:0] y_out
);
  import dpc_pkg::*;

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        x_out[i*COORD_W +: COORD_W] <= '0;
        y_out[i*COORD_W +: COORD_W] <= '0;
      end else if (copy_en_in) begin
        x_out[i*COORD_W +: COORD_W] <= copy_x_in[i*COORD_W +: COORD_W];
        y_out[i*COORD_W +: COORD_W] <= copy_y_in[i*COORD_W +: COORD_W];
      end else if (wr_en_in && wr_idx_in == IDX_W'(i)) begin
        x_out[i*COORD_W +: COORD_W] <= wr_x_in;
        y_out[i*COORD_W +: COORD_W] <= wr_y_in;
      end
    end
  end

endmodule

// file: core/dpc_pkg.sv
// Purpose: Constants and types for the defective pixel correction block
// Assumes: One clock, plain register port, external non-volatile word store
// Notes:   Offsets are word addresses on the register port
//
// Overview of operation
// [R1] Switch on alters listed pixels, off passes
// [R2] Average mode uses mean of neighbours
// [R3] Highlight mode forces maximum pixel value
// [R4] Settable entry total sizes staged list
// [R5] Selector is zero based, up to total-1
// [R6] X and Y fields follow the selector
// [R7] Coordinates relative to full sensor image
// [R8] Edits touch staged copy only until commit
// [R9] Commit copies staged list into active table
// [R10] Save writes store; store loaded at boot
// [R11] Factory restore rewrites active and stored lists
// [R12] Streaming during table load may glitch
// [R13] Software adds entry: total, selector, coords, commit
// [R14] Out of range selector writes are rejected
package dpc_pkg;

  localparam int PIX_W   = 12;
  localparam int COORD_W = 12;
  localparam int DEPTH   = 16;
  localparam int IDX_W   = 4;
  localparam int CNT_W   = 5;
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 32;
  localparam int NVM_AW  = 8;

  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_INDEX  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_X      = 4'h3;
  localparam logic [ADDR_W-1:0] REG_Y      = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CMD    = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CMD_COMMIT_BIT = 0;
  localparam int CMD_SAVE_BIT   = 1;
  localparam int CMD_FACT_BIT   = 2;

  localparam logic            RST_ENABLE = 1'b1;
  localparam logic [NVM_AW-1:0] NVM_USER_BASE = 8'h00;
  localparam logic [NVM_AW-1:0] NVM_FACT_BASE = 8'h80;

  typedef enum logic [1:0] {
    DPC_MODE_AVERAGE   = 2'h0,
    DPC_MODE_HIGHLIGHT = 2'h1,
    DPC_MODE_ZERO      = 2'h2
  } dpc_mode_type;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_READ = 3'b001,
    SEQ_WAIT = 3'b011,
    SEQ_TAKE = 3'b010,
    SEQ_SAVE = 3'b110
  } dpc_seq_type;

endpackage

// file: core/dpc_top.sv
// Purpose: Table based defective pixel correction on a pixel stream
// Assumes: Stream marks first pixel of frame and last pixel of each line
// Notes:   Two cycles of latency; table store is an external word memory
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module dpc_top #(
  parameter int PIX_W   = dpc_pkg::PIX_W,
  parameter int COORD_W = dpc_pkg::COORD_W,
  parameter int DEPTH   = dpc_pkg::DEPTH
) (
  input  wire logic                       CLOCK_IN,
  input  wire logic                       RESET_N_IN,
  input  wire logic [dpc_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [dpc_pkg::DATA_W-1:0] REG_WDATA_IN,
  input  wire logic                       REG_WR_IN,
  input  wire logic                       REG_RD_IN,
  output logic      [dpc_pkg::DATA_W-1:0] REG_RDATA_OUT,
  input  wire logic                       PIX_VALID_IN,
  input  wire logic [PIX_W-1:0]           PIX_DATA_IN,
  input  wire logic                       PIX_SOF_IN,
  input  wire logic                       PIX_EOL_IN,
  input  wire logic [COORD_W-1:0]         WINDOW_X_OFFSET_IN,
  input  wire logic [COORD_W-1:0]         WINDOW_Y_OFFSET_IN,
  output logic                            PIX_VALID_OUT,
  output logic      [PIX_W-1:0]           PIX_DATA_OUT,
  output logic                            PIX_SOF_OUT,
  output logic                            PIX_EOL_OUT,
  output logic                            NVM_RD_OUT,
  output logic                            NVM_WR_OUT,
  output logic      [dpc_pkg::NVM_AW-1:0] NVM_ADDR_OUT,
  output logic      [dpc_pkg::DATA_W-1:0] NVM_WDATA_OUT,
  input  wire logic [dpc_pkg::DATA_W-1:0] NVM_RDATA_IN
);
  import dpc_pkg::*;

  logic                     enable;
  dpc_mode_type             mode;
  logic [CNT_W-1:0]         staged_count;
  logic [CNT_W-1:0]         active_count;
  logic [IDX_W-1:0]         index;
  logic [DEPTH*COORD_W-1:0] staged_x;
  logic [DEPTH*COORD_W-1:0] staged_y;
  logic [DEPTH*COORD_W-1:0] active_x;
  logic [DEPTH*COORD_W-1:0] active_y;
  logic [COORD_W-1:0]       sel_x;
  logic [COORD_W-1:0]       sel_y;

  dpc_seq_type              state;
  logic [CNT_W-1:0]         step;
  logic [CNT_W-1:0]         seq_len;
  logic                     restore;
  logic [NVM_AW-1:0]        src_base;
  logic [CNT_W-1:0]         load_len;
  logic                     seq_done;
  logic                     busy;

  logic                     wr_ctrl;
  logic                     wr_count;
  logic                     wr_index;
  logic                     wr_x;
  logic                     wr_y;
  logic                     wr_cmd;
  logic                     commit;
  logic                     index_ok;

  logic                     tbl_wr;
  logic [IDX_W-1:0]         tbl_idx;
  logic [COORD_W-1:0]       tbl_x;
  logic [COORD_W-1:0]       tbl_y;
  logic                     load_wr;

  logic                     next_nvm_rd;
  logic                     next_nvm_wr;
  logic [NVM_AW-1:0]        next_nvm_addr;
  logic [DATA_W-1:0]        next_nvm_wdata;

  // Register port decode
  assign busy     = (state != SEQ_IDLE);
  assign wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == REG_CTRL);
  assign wr_count = REG_WR_IN && (REG_ADDR_IN == REG_COUNT) && !busy;
  assign wr_index = REG_WR_IN && (REG_ADDR_IN == REG_INDEX) && !busy;
  assign wr_x     = REG_WR_IN && (REG_ADDR_IN == REG_X) && !busy;
  assign wr_y     = REG_WR_IN && (REG_ADDR_IN == REG_Y) && !busy;
  assign wr_cmd   = REG_WR_IN && (REG_ADDR_IN == REG_CMD) && !busy;
  assign commit   = wr_cmd && REG_WDATA_IN[CMD_COMMIT_BIT];
  assign index_ok = (CNT_W'(index) < staged_count);

  assign sel_x = staged_x[index*COORD_W +: COORD_W]; // [R6]
  assign sel_y = staged_y[index*COORD_W +: COORD_W]; // [R6]

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      enable <= RST_ENABLE;
      mode   <= DPC_MODE_AVERAGE;
    end else if (wr_ctrl) begin
      enable <= REG_WDATA_IN[CTRL_EN_BIT];
      mode   <= dpc_mode_type'(REG_WDATA_IN[CTRL_MODE_LSB +: 2]);
    end
  end

  // Staged entry total, loaded also from the store
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      staged_count <= '0;
    end else if (load_wr && step == '0) begin
      staged_count <= load_len;
    end else if (wr_count && REG_WDATA_IN <= DATA_W'(DEPTH)) begin
      staged_count <= REG_WDATA_IN[CNT_W-1:0]; // [R4]
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      index <= '0;
    end else if (wr_index && REG_WDATA_IN < DATA_W'(staged_count)) begin
      index <= REG_WDATA_IN[IDX_W-1:0]; // [R5] [R14]
    end
  end

  // Active total changes only on commit or table load
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      active_count <= '0;
    end else if (load_wr && step == '0) begin
      active_count <= load_len; // [R10] [R11]
    end else if (commit) begin
      active_count <= staged_count; // [R9]
    end
  end

  // Staged entry write: store load has priority over software
  always_comb begin
    load_wr = (state == SEQ_TAKE);
    tbl_wr  = 1'b0;
    tbl_idx = index;
    tbl_x   = sel_x;
    tbl_y   = sel_y;
    if (load_wr && step != '0) begin
      tbl_wr  = 1'b1;
      tbl_idx = IDX_W'(step - 1'b1);
      tbl_x   = NVM_RDATA_IN[COORD_W-1:0];
      tbl_y   = NVM_RDATA_IN[2*COORD_W-1:COORD_W];
    end else if ((wr_x || wr_y) && index_ok) begin
      tbl_wr = 1'b1; // [R6] [R8]
      if (wr_x) begin
        tbl_x = REG_WDATA_IN[COORD_W-1:0];
      end
      if (wr_y) begin
        tbl_y = REG_WDATA_IN[COORD_W-1:0];
      end
    end
  end

  dpc_entry_table #(
    .DEPTH   (DEPTH),
    .IDX_W   (IDX_W),
    .COORD_W (COORD_W)
  ) u_staged (
    .clk_in     (CLOCK_IN),
    .rst_n_in   (RESET_N_IN),
    .wr_en_in   (tbl_wr),
    .wr_idx_in  (tbl_idx),
    .wr_x_in    (tbl_x),
    .wr_y_in    (tbl_y),
    .copy_en_in (1'b0),
    .copy_x_in  ('0),
    .copy_y_in  ('0),
    .x_out      (staged_x),
    .y_out      (staged_y)
  );

  // Active table: whole copy on commit, entry load from the store
  dpc_entry_table #(
    .DEPTH   (DEPTH),
    .IDX_W   (IDX_W),
    .COORD_W (COORD_W)
  ) u_active (
    .clk_in     (CLOCK_IN),
    .rst_n_in   (RESET_N_IN),
    .wr_en_in   (load_wr && step != '0), // [R12]
    .wr_idx_in  (tbl_idx),
    .wr_x_in    (tbl_x),
    .wr_y_in    (tbl_y),
    .copy_en_in (commit), // [R9]
    .copy_x_in  (staged_x),
    .copy_y_in  (staged_y),
    .x_out      (active_x),
    .y_out      (active_y)
  );

  // Store sequencer: word 0 is the total, words 1..N the entries
  assign load_len = (NVM_RDATA_IN > DATA_W'(DEPTH)) ? CNT_W'(DEPTH)
                                                    : NVM_RDATA_IN[CNT_W-1:0];
  assign seq_done = (step == '0) ? (load_len == '0) : (step == seq_len);

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state    <= SEQ_READ; // [R10]
      step     <= '0;
      seq_len  <= '0;
      restore  <= 1'b0;
      src_base <= NVM_USER_BASE;
    end else begin
      case (state)
        SEQ_IDLE: begin
          step <= '0;
          if (wr_cmd && REG_WDATA_IN[CMD_FACT_BIT]) begin
            state    <= SEQ_READ; // [R11]
            restore  <= 1'b1;
            src_base <= NVM_FACT_BASE;
          end else if (wr_cmd && REG_WDATA_IN[CMD_SAVE_BIT]) begin
            state   <= SEQ_SAVE; // [R10]
            seq_len <= staged_count;
          end
        end
        SEQ_READ: begin
          state <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          state <= SEQ_TAKE;
        end
        SEQ_TAKE: begin
          if (step == '0) begin
            seq_len <= load_len;
          end
          if (seq_done) begin
            state   <= SEQ_IDLE;
            restore <= 1'b0;
          end else begin
            state <= SEQ_READ;
            step  <= step + 1'b1;
          end
        end
        SEQ_SAVE: begin
          if (step == seq_len) begin
            state <= SEQ_IDLE;
          end else begin
            step <= step + 1'b1;
          end
        end
        default: begin
          state <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    next_nvm_rd    = 1'b0;
    next_nvm_wr    = 1'b0;
    next_nvm_addr  = src_base + NVM_AW'(step);
    next_nvm_wdata = '0;
    case (state)
      SEQ_READ: begin
        next_nvm_rd = 1'b1;
      end
      SEQ_TAKE: begin
        next_nvm_wr   = restore; // [R11]
        next_nvm_addr = NVM_USER_BASE + NVM_AW'(step);
        if (step == '0) begin
          next_nvm_wdata = DATA_W'(load_len);
        end else begin
          next_nvm_wdata = DATA_W'({tbl_y, tbl_x});
        end
      end
      SEQ_SAVE: begin
        next_nvm_wr   = 1'b1; // [R10]
        next_nvm_addr = NVM_USER_BASE + NVM_AW'(step);
        if (step == '0) begin
          next_nvm_wdata = DATA_W'(seq_len);
        end else begin
          next_nvm_wdata = DATA_W'({staged_y[(step-1'b1)*COORD_W +: COORD_W],
                                    staged_x[(step-1'b1)*COORD_W +: COORD_W]});
        end
      end
      default: begin
        next_nvm_rd = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      NVM_RD_OUT    <= 1'b0;
      NVM_WR_OUT    <= 1'b0;
      NVM_ADDR_OUT  <= '0;
      NVM_WDATA_OUT <= '0;
    end else begin
      NVM_RD_OUT    <= next_nvm_rd;
      NVM_WR_OUT    <= next_nvm_wr;
      NVM_ADDR_OUT  <= next_nvm_addr;
      NVM_WDATA_OUT <= next_nvm_wdata;
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT <= '0;
    end else if (REG_RD_IN) begin
      if (REG_ADDR_IN == REG_CTRL) begin
        REG_RDATA_OUT <= DATA_W'({mode, enable});
      end else if (REG_ADDR_IN == REG_COUNT) begin
        REG_RDATA_OUT <= DATA_W'(staged_count);
      end else if (REG_ADDR_IN == REG_INDEX) begin
        REG_RDATA_OUT <= DATA_W'(index);
      end else if (REG_ADDR_IN == REG_X) begin
        REG_RDATA_OUT <= DATA_W'(sel_x); // [R6]
      end else if (REG_ADDR_IN == REG_Y) begin
        REG_RDATA_OUT <= DATA_W'(sel_y);
      end else if (REG_ADDR_IN == REG_STATUS) begin
        REG_RDATA_OUT <= DATA_W'({active_count, busy});
      end else begin
        REG_RDATA_OUT <= '0;
      end
    end else begin
      REG_RDATA_OUT <= '0;
    end
  end

  // Pixel coordinates in full sensor terms
  logic [COORD_W-1:0]   col;
  logic [COORD_W-1:0]   row;
  logic [COORD_W-1:0]   in_x;
  logic [COORD_W-1:0]   in_y;
  logic                 cur_valid;
  logic [PIX_W-1:0]     cur_data;
  logic [COORD_W-1:0]   cur_x;
  logic [COORD_W-1:0]   cur_y;
  logic                 cur_sof;
  logic                 cur_eol;
  logic [PIX_W-1:0]     left_data;
  logic                 has_left;
  logic                 emit;
  logic [DEPTH-1:0]     hit_vec;
  logic [PIX_W:0]       pair_sum;
  logic [PIX_W-1:0]     fixed;

  assign in_x = PIX_SOF_IN ? '0 : col;
  assign in_y = PIX_SOF_IN ? '0 : row;

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      col <= '0;
      row <= '0;
    end else if (PIX_VALID_IN) begin
      col <= PIX_EOL_IN ? '0 : in_x + 1'b1;
      row <= PIX_EOL_IN ? in_y + 1'b1 : in_y;
    end
  end

  // Current pixel waits for its right neighbour or its line end
  assign emit = cur_valid && (PIX_VALID_IN || cur_eol);

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cur_valid <= 1'b0;
      cur_data  <= '0;
      cur_x     <= '0;
      cur_y     <= '0;
      cur_sof   <= 1'b0;
      cur_eol   <= 1'b0;
      left_data <= '0;
      has_left  <= 1'b0;
    end else if (PIX_VALID_IN) begin
      cur_valid <= 1'b1;
      cur_data  <= PIX_DATA_IN;
      cur_x     <= in_x + WINDOW_X_OFFSET_IN; // [R7]
      cur_y     <= in_y + WINDOW_Y_OFFSET_IN; // [R7]
      cur_sof   <= PIX_SOF_IN;
      cur_eol   <= PIX_EOL_IN;
      left_data <= cur_data;
      has_left  <= cur_valid && !cur_eol && !PIX_SOF_IN;
    end else if (emit) begin
      cur_valid <= 1'b0;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_hit
    assign hit_vec[i] = (CNT_W'(i) < active_count)
                     && (active_x[i*COORD_W +: COORD_W] == cur_x)
                     && (active_y[i*COORD_W +: COORD_W] == cur_y);
  end

  assign pair_sum = {1'b0, left_data} + {1'b0, PIX_DATA_IN};

  always_comb begin
    fixed = cur_data;
    if (enable && |hit_vec) begin // [R1]
      case (mode)
        DPC_MODE_HIGHLIGHT: begin
          fixed = '1; // [R3]
        end
        DPC_MODE_ZERO: begin
          fixed = '0;
        end
        default: begin
          if (has_left && !cur_eol) begin
            fixed = pair_sum[PIX_W:1]; // [R2]
          end else if (has_left) begin
            fixed = left_data; // [R2]
          end else if (!cur_eol) begin
            fixed = PIX_DATA_IN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PIX_VALID_OUT <= 1'b0;
      PIX_DATA_OUT  <= '0;
      PIX_SOF_OUT   <= 1'b0;
      PIX_EOL_OUT   <= 1'b0;
    end else begin
      PIX_VALID_OUT <= emit;
      if (emit) begin
        PIX_DATA_OUT <= fixed;
        PIX_SOF_OUT  <= cur_sof;
        PIX_EOL_OUT  <= cur_eol;
      end
    end
  end

endmodule

// file: verif/dpc_nvm_model.sv
// Purpose: Word store model behind the table store port
// Assumes: Answer is due in the cycle after a read pulse
// Notes:   Idle read data toggles so a stale word never looks valid
`timescale 1ns/1ps
module dpc_nvm_model (
  input  wire logic                       clk_in,
  input  wire logic                       rd_in,
  input  wire logic                       wr_in,
  input  wire logic [dpc_pkg::NVM_AW-1:0] addr_in,
  input  wire logic [dpc_pkg::DATA_W-1:0] wdata_in,
  output logic      [dpc_pkg::DATA_W-1:0] rdata_out
);
  import dpc_pkg::*;
  logic [DATA_W-1:0] mem [0:255];
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    mem[8'h00] = 32'h1;
    mem[8'h01] = 32'h3;
    mem[8'h80] = 32'h3;
    mem[8'h81] = 32'h1006;
    mem[8'h82] = 32'h4;
    mem[8'h83] = 32'h1000;
    rdata_out  = 32'h0;
  end
  always @(posedge clk_in) begin
    if (wr_in) mem[addr_in] <= wdata_in;
    rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
  end
endmodule

// file: verif/dpc_top_sva.sv
// Purpose: Port checks for the pixel correction block
// Assumes: Lines stream without gaps; control changes while idle
// Notes:   Control word is shadowed from register writes
`timescale 1ns/1ps
module dpc_top_sva (
  input wire logic                       CLOCK_IN,
  input wire logic                       RESET_N_IN,
  input wire logic [dpc_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [dpc_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic                       REG_WR_IN,
  input wire logic                       REG_RD_IN,
  input wire logic [dpc_pkg::DATA_W-1:0] REG_RDATA_OUT,
  input wire logic                       PIX_VALID_IN,
  input wire logic [dpc_pkg::PIX_W-1:0]  PIX_DATA_IN,
  input wire logic                       PIX_EOL_IN,
  input wire logic                       PIX_VALID_OUT,
  input wire logic [dpc_pkg::PIX_W-1:0]  PIX_DATA_OUT,
  input wire logic                       PIX_EOL_OUT,
  input wire logic                       NVM_RD_OUT,
  input wire logic                       NVM_WR_OUT,
  input wire logic [dpc_pkg::NVM_AW-1:0] NVM_ADDR_OUT,
  input wire logic [dpc_pkg::DATA_W-1:0] NVM_WDATA_OUT
);
  import dpc_pkg::*;
  logic       en;
  logic [1:0] mode;
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      en   <= RST_ENABLE;
      mode <= 2'h0;
    end else if (REG_WR_IN && REG_ADDR_IN == REG_CTRL) begin
      en   <= REG_WDATA_IN[CTRL_EN_BIT];
      mode <= REG_WDATA_IN[CTRL_MODE_LSB+:2];
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_rd_idle;
    !REG_RD_IN |=> REG_RDATA_OUT == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_eol;
    PIX_VALID_IN && PIX_EOL_IN |-> ##2 PIX_VALID_OUT && PIX_EOL_OUT;
  endproperty
  a_eol: assert property (p_eol) else $error("line end pixel missing");
  property p_pass;
    !en && PIX_VALID_OUT && $past(PIX_VALID_IN, 2) |-> PIX_DATA_OUT == $past(PIX_DATA_IN, 2);
  endproperty
  a_pass: assert property (p_pass) else $error("pixel altered while off");
  property p_hilite;
    en && mode == 2'h1 && PIX_VALID_OUT && $past(PIX_VALID_IN, 2)
      |-> PIX_DATA_OUT == '1 || PIX_DATA_OUT == $past(PIX_DATA_IN, 2);
  endproperty
  a_hilite: assert property (p_hilite) else $error("bad highlight value");
  property p_rd_gap;
    NVM_RD_OUT |=> !NVM_RD_OUT [*2];
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("store reads too close");
  property p_boot;
    $rose(RESET_N_IN) |-> ##[1:2] NVM_RD_OUT && NVM_ADDR_OUT == NVM_USER_BASE;
  endproperty
  a_boot: assert property (p_boot) else $error("no boot load of list");
  property p_wr_user;
    NVM_WR_OUT |-> NVM_ADDR_OUT < NVM_FACT_BASE;
  endproperty
  a_wr_user: assert property (p_wr_user) else $error("factory list written");
  property p_save_count;
    NVM_WR_OUT && NVM_ADDR_OUT == NVM_USER_BASE |-> NVM_WDATA_OUT <= 32'h10;
  endproperty
  a_save_count: assert property (p_save_count) else $error("stored count too big");
endmodule
bind dpc_top dpc_top_sva i_dpc_top_sva (.*);

// file: verif/dpc_top_tb.sv
// Purpose: Self-checking bench for the pixel correction block
// Assumes: Store model answers reads; stream idles around edits
// Notes:   Expected pixels come from the bench copy of the list
`timescale 1ns/1ps
module dpc_top_tb;
  import dpc_pkg::*;
  localparam int W = 8;
  localparam int H = 2;
  logic               clk     = 1'h0;
  logic               rst_n   = 1'h0;
  logic [ADDR_W-1:0]  addr    = '0;
  logic [DATA_W-1:0]  wdata   = '0;
  logic               wr_s    = 1'h0;
  logic               rd_s    = 1'h0;
  logic [DATA_W-1:0]  rdata;
  logic               pix_v   = 1'h0;
  logic [PIX_W-1:0]   pix_d   = '0;
  logic               pix_sof = 1'h0;
  logic               pix_eol = 1'h0;
  logic [COORD_W-1:0] x_off   = '0;
  logic [COORD_W-1:0] y_off   = '0;
  logic               out_v;
  logic [PIX_W-1:0]   out_d;
  logic               out_sof;
  logic               nvm_rd;
  logic               nvm_wr;
  logic [NVM_AW-1:0]  nvm_addr;
  logic [DATA_W-1:0]  nvm_wdata;
  logic [DATA_W-1:0]  nvm_rdata;
  logic [PIX_W:0]     q[$];
  int                 ax[DEPTH];
  int                 ay[DEPTH];
  int                 an      = 1;
  logic               en      = 1'h1;
  logic [1:0]         mode    = 2'h0;
  int                 fails   = 0;
  int                 n_tests = 0;

  dpc_top i_dpc_top (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
    .PIX_VALID_IN(pix_v), .PIX_DATA_IN(pix_d), .PIX_SOF_IN(pix_sof), .PIX_EOL_IN(pix_eol),
    .WINDOW_X_OFFSET_IN(x_off), .WINDOW_Y_OFFSET_IN(y_off), .PIX_VALID_OUT(out_v),
    .PIX_DATA_OUT(out_d), .PIX_SOF_OUT(out_sof), .PIX_EOL_OUT(), .NVM_RD_OUT(nvm_rd),
    .NVM_WR_OUT(nvm_wr), .NVM_ADDR_OUT(nvm_addr), .NVM_WDATA_OUT(nvm_wdata),
    .NVM_RDATA_IN(nvm_rdata));
  dpc_nvm_model i_dpc_nvm_model (.clk_in(clk), .rd_in(nvm_rd), .wr_in(nvm_wr),
    .addr_in(nvm_addr), .wdata_in(nvm_wdata), .rdata_out(nvm_rdata));

  always #5 clk = ~clk;
  always @(posedge clk) if (out_v === 1'h1) q.push_back({out_sof, out_d});

  function automatic int pix(int c, int r);
    return c * c * 8 + r * 256 + 5;
  endfunction
  function automatic logic [PIX_W-1:0] exp_pix(int c, int r);
    logic hit;
    hit = 1'h0;
    for (int k = 0; k < an; k++) if (ax[k] == c + x_off && ay[k] == r + y_off) hit = 1'h1;
    if (!en || !hit) return PIX_W'(pix(c, r));
    if (mode == 2'h1) return '1;
    if (mode == 2'h2) return '0;
    if (c == 0) return PIX_W'(pix(1, r));
    if (c == W - 1) return PIX_W'(pix(W - 2, r));
    return PIX_W'((pix(c - 1, r) + pix(c + 1, r)) >> 1);
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    wr_s  <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_s  <= 1'h0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    rd_s <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'h0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic rd_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e, string nm);
    logic [DATA_W-1:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic wait_idle();
    logic [DATA_W-1:0] s;
    for (int i = 0; i < 100; i++) begin
      rd(REG_STATUS, s);
      if (s[0] === 1'h0) return;
    end
    fails++;
    $display("CHECK FAILED busy expected 0 seen 1");
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    en = 1'h1;
    mode = 2'h0;
  endtask
  task automatic set_ctrl(logic e, logic [1:0] m);
    wr(REG_CTRL, {29'h0, m, e});
    en = e;
    mode = m;
  endtask
  task automatic run_frame(string nm);
    int k;
    q.delete();
    for (int r = 0; r < H; r++) for (int c = 0; c < W; c++) begin
      @(posedge clk);
      pix_v   <= 1'h1;
      pix_d   <= PIX_W'(pix(c, r));
      pix_sof <= (c == 0 && r == 0);
      pix_eol <= (c == W - 1);
    end
    @(posedge clk);
    pix_v <= 1'h0;
    repeat (4) @(posedge clk);
    chk({nm, " count"}, W * H, q.size());
    k = 0;
    for (int r = 0; r < H; r++) for (int c = 0; c < W; c++) begin
      chk(nm, {c == 0 && r == 0, exp_pix(c, r)}, (k < q.size()) ? q[k] : 'x);
      k++;
    end
  endtask

  task automatic t_boot();
    wait_idle();
    ax[0] = 3;
    ay[0] = 0;
    rd_chk(REG_COUNT, 32'h1, "boot count");
    rd_chk(REG_X, 32'h3, "boot x");
    rd_chk(REG_STATUS, 32'h2, "boot active");
    run_frame("boot frame");
    $display("test boot done");
  endtask
  task automatic t_edit();
    wr(REG_COUNT, 32'h11);
    rd_chk(REG_COUNT, 32'h1, "count over");
    wr(REG_COUNT, 32'h2);
    wr(REG_INDEX, 32'h2);
    rd_chk(REG_INDEX, 32'h0, "index over");
    wr(REG_INDEX, 32'h1);
    wr(REG_X, 32'h5);
    wr(REG_Y, 32'h1);
    rd_chk(REG_X, 32'h5, "x field");
    rd_chk(REG_Y, 32'h1, "y field");
    rd_chk(REG_STATUS, 32'h2, "active unchanged");
    run_frame("staged only");
    wr(REG_CMD, 32'h1);
    rd_chk(REG_STATUS, 32'h4, "active committed");
    an = 2;
    ax[1] = 5;
    ay[1] = 1;
    run_frame("committed");
    rd_chk(4'hf, 32'h0, "unmapped");
    $display("test edit done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      set_ctrl(m != 0, 2'(m));
      run_frame("mode frame");
    end
    set_ctrl(1'h1, 2'h0);
    $display("test modes done");
  endtask
  task automatic t_window();
    @(posedge clk);
    x_off <= 12'h1;
    y_off <= 12'h1;
    run_frame("window");
    @(posedge clk);
    x_off <= 12'h0;
    y_off <= 12'h0;
    $display("test window done");
  endtask
  task automatic t_save();
    wr(REG_CMD, 32'h2);
    wait_idle();
    chk("store count", 32'h2, i_dpc_nvm_model.mem[0]);
    chk("store entry", 32'h1005, i_dpc_nvm_model.mem[2]);
    do_reset();
    wait_idle();
    rd_chk(REG_STATUS, 32'h4, "reboot active");
    run_frame("reboot frame");
    $display("test save done");
  endtask
  task automatic t_factory();
    wr(REG_CMD, 32'h6);
    wait_idle();
    an = 3;
    ax[0] = 6;
    ay[0] = 1;
    ax[1] = 4;
    ay[1] = 0;
    ax[2] = 0;
    ay[2] = 1;
    rd_chk(REG_COUNT, 32'h3, "factory count");
    rd_chk(REG_STATUS, 32'h6, "factory active");
    chk("factory store", 32'h1000, i_dpc_nvm_model.mem[3]);
    run_frame("factory frame");
    $display("test factory done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_boot();
    t_edit();
    t_modes();
    t_window();
    t_save();
    t_factory();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
